//--- hdl/sor_map.vh
// Register offsets, field positions and reset values of the system option registers
`ifndef SOR_MAP_VH
`define SOR_MAP_VH
// ============================================================
// Register indices on the internal register port
`define SOR_ADDR_W 2
`define SOR_IDX_FORCE_RESET 2'h0
`define SOR_IDX_OPTIONS_ONE 2'h1
`define SOR_IDX_OPTIONS_TWO 2'h2
// ============================================================
// Force-reset register fields
`define SOR_FRC_BIT 0
`define SOR_FRC_READ 8'h00
// ============================================================
// First options register fields
`define SOR_O1_WDG_EN 7
`define SOR_O1_WDG_LONG 6
`define SOR_O1_STOP_OK 5
`define SOR_O1_DBG_PIN 1
`define SOR_O1_RST_PIN 0
`define SOR_O1_IMPL_MASK 8'hE3
`define SOR_O1_RESET 8'hC2
// ============================================================
// Second options register fields
`define SOR_O2_WDG_CLK 7
`define SOR_O2_SPI_FILT 4
`define SOR_O2_SPI_PINS 3
`define SOR_O2_CMP2_CAP 2
`define SOR_O2_TWI_PINS 1
`define SOR_O2_CMP1_CAP 0
`define SOR_O2_IMPL_MASK 8'h9F
`define SOR_O2_RESET 8'h00
// ============================================================
// Reset generator pulse length in bus clocks; force_reset_q stays high one clock longer
`define SOR_FRC_PULSE_CYC 4'h4
`endif

//--- hdl/sor_once_reg.v
// Write-once register with implemented-bit mask and sticky lock
`timescale 1ns/1ns
module sor_once_reg #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] MASK = 8'hFF,
  parameter [WIDTH-1:0] RESET_VAL = 8'h00
) (
  input wire sys_clk, // Bus clock
  input wire rst_b, // Asynchronous reset, active low
  input wire clr, // Synchronous return to reset value and unlock
  input wire wr_en, // Write strobe for this register
  input wire [WIDTH-1:0] wr_data, // Write data
  input wire [WIDTH-1:0] keep_mask, // Bits that keep their value on clr
  output reg [WIDTH-1:0] value_q, // Stored value
  output reg locked_q // High once the first write is taken
);
  reg [WIDTH-1:0] value_d;
  reg locked_d;

  always @* begin
    value_d = value_q;
    locked_d = locked_q;
    if (clr) begin
      value_d = (value_q & keep_mask) | (RESET_VAL & ~keep_mask);
      locked_d = 1'b0;
    end else if (wr_en && !locked_q) begin
      // Unimplemented bits stay zero whatever is written
      value_d = wr_data & MASK;
      locked_d = 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      value_q <= RESET_VAL;
      locked_q <= 1'b0;
    end else begin
      value_q <= value_d;
      locked_q <= locked_d;
    end
  end
endmodule // sor_once_reg

//--- hdl/sor_reset_gen.v
// Stretches a one-cycle reset request into a fixed-length reset pulse
`timescale 1ns/1ns
`include "sor_map.vh"
module sor_reset_gen (
  input wire sys_clk, // Bus clock
  input wire rst_b, // Asynchronous reset, active low
  input wire req, // One-cycle reset request
  output reg active_q // Reset pulse, high while counting
);
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;

  always @* begin
    cnt_d = cnt_q;
    if (req && cnt_q == 4'h0) begin
      cnt_d = `SOR_FRC_PULSE_CYC;
    end else if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      active_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      active_q <= (cnt_d != 4'h0);
    end
  end
endmodule // sor_reset_gen

//--- hdl/sor_system_options.v
// System option registers: debug force reset and two write-once option registers
//
// Overview of operation
// - Program writes to force-reset register ignored
// - Force-reset register always reads zero
// - Debug write of one forces full reset
// - Forced reset leaves reset-status flags clear
// - First options register writable once, always readable
// - Bit 7 enables watchdog with timeout reset
// - Bit 6 selects short or long timeout
// - Bit 5 allows stop, else illegal-opcode reset
// - Bit 1 selects debug pin function
// - Debug pin enable set after every reset
// - Bit 0 makes shared pin reset input
// - Reset pin enable cleared only by power-on
// - Second register bit 7 selects watchdog clock
// - Bit 4 enables serial port input filter
// - Bit 3 moves serial port pins
// - Bit 2 routes second comparator to capture
// - Bit 1 moves two-wire pins
// - Bit 0 routes first comparator to capture
`timescale 1ns/1ns
`include "sor_map.vh"
module sor_system_options (
  input wire sys_clk, // Bus clock, 10 MHz
  input wire rst_b, // Power-on reset, asynchronous, active low
  input wire sys_reset, // Any other device reset, synchronous, active high
  input wire [`SOR_ADDR_W-1:0] reg_addr, // Register index
  input wire reg_wr, // Write strobe from the running program
  input wire dbg_wr, // Write strobe from a background debug write command
  input wire reg_rd, // Read strobe
  input wire [7:0] reg_wdata, // Write data
  input wire stop_exec, // Stop instruction being executed
  output reg [7:0] reg_rdata_q, // Read data, valid the cycle after reg_rd
  output reg force_reset_q, // Forced device reset pulse
  output reg status_suppress_q, // Keeps reset-source status flags clear
  output reg illegal_stop_q, // Illegal-opcode reset request
  output reg stop_grant_q, // Stop mode entry granted
  output reg watchdog_enable_q, // Watchdog enabled
  output reg watchdog_long_timeout_q, // Long watchdog period selected
  output reg watchdog_clock_select_q, // 1: bus clock, 0: internal 1 kHz clock
  output reg debug_pin_enable_q, // Shared pin is the background debug pin
  output reg reset_pin_enable_q, // Shared pin is reset input with pullup
  output reg reset_pin_pullup_q, // Internal pullup on reset pin
  output reg serial_port_filter_enable_q, // Serial port input filter on
  output reg serial_port_pin_select_q, // 0: port B 2..5, 1: port E 0..3
  output reg comparator2_to_capture_q, // Second comparator drives second timer channel 0
  output reg two_wire_pin_select_q, // 0: port A 2/3, 1: port B 6/7
  output reg comparator1_to_capture_q // First comparator drives first timer channel 0
);
  // ============================================================
  // Decode
  function hit;
    input [`SOR_ADDR_W-1:0] addr;
    input [`SOR_ADDR_W-1:0] idx;
    begin
      hit = (addr == idx);
    end
  endfunction

  wire frc_req;
  wire frc_active;
  wire any_reset;
  wire [7:0] opt1_q;
  wire [7:0] opt2_q;
  wire sel_frc;
  wire sel_opt1;
  wire sel_opt2;
  wire opt1_wr;
  wire opt2_wr;
  reg [7:0] rdata_d;

  // ============================================================
  // Reset values and write decode
  // Output flops reset to the register reset values, so they agree with a read
  localparam [7:0] O1_RST = `SOR_O1_RESET;
  localparam [7:0] O2_RST = `SOR_O2_RESET;
  // Only the reset pin enable survives a reset other than power-on
  localparam [7:0] O1_KEEP = 8'h01 << `SOR_O1_RST_PIN;
  localparam [7:0] O2_KEEP = 8'h00;

  assign sel_frc = hit(reg_addr, `SOR_IDX_FORCE_RESET);
  assign sel_opt1 = hit(reg_addr, `SOR_IDX_OPTIONS_ONE);
  assign sel_opt2 = hit(reg_addr, `SOR_IDX_OPTIONS_TWO);
  // Debug writes to the option registers obey the same lock as program writes
  assign opt1_wr = (reg_wr | dbg_wr) && sel_opt1;
  assign opt2_wr = (reg_wr | dbg_wr) && sel_opt2;

  // Only a background debug write reaches the force-reset bit
  assign frc_req = dbg_wr && !reg_wr && sel_frc && reg_wdata[`SOR_FRC_BIT];
  // The forced reset also clears the option registers, as any reset does
  assign any_reset = sys_reset | frc_active;

  // ============================================================
  // Forced reset pulse
  sor_reset_gen u_frc (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .req(frc_req),
    .active_q(frc_active)
  );

  // ============================================================
  // Option registers
  // Reset pin enable survives every reset but power-on
  sor_once_reg #(
    .WIDTH(8),
    .MASK(`SOR_O1_IMPL_MASK),
    .RESET_VAL(`SOR_O1_RESET)
  ) u_opt1 (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clr(any_reset),
    .wr_en(opt1_wr),
    .wr_data(reg_wdata),
    .keep_mask(O1_KEEP),
    .value_q(opt1_q),
    .locked_q()
  );

  // Whole register is treated as write-once for simplicity of locking
  sor_once_reg #(
    .WIDTH(8),
    .MASK(`SOR_O2_IMPL_MASK),
    .RESET_VAL(`SOR_O2_RESET)
  ) u_opt2 (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clr(any_reset),
    .wr_en(opt2_wr),
    .wr_data(reg_wdata),
    .keep_mask(O2_KEEP),
    .value_q(opt2_q),
    .locked_q()
  );

  // ============================================================
  // Read mux
  always @* begin
    rdata_d = 8'h00;
    if (hit(reg_addr, `SOR_IDX_FORCE_RESET)) begin
      rdata_d = `SOR_FRC_READ;
    end else if (hit(reg_addr, `SOR_IDX_OPTIONS_ONE)) begin
      rdata_d = opt1_q & `SOR_O1_IMPL_MASK;
    end else if (hit(reg_addr, `SOR_IDX_OPTIONS_TWO)) begin
      rdata_d = opt2_q & `SOR_O2_IMPL_MASK;
    end
  end

  // ============================================================
  // Read data
  // Zero between reads, so a stale byte never passes for a fresh answer
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // ============================================================
  // Forced reset outputs
  // The request itself raises the pulse so that no cycle is lost
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      force_reset_q <= 1'b0;
    end else begin
      force_reset_q <= frc_active | frc_req;
    end
  end

  // Flags stay suppressed for the whole forced pulse
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_suppress_q <= 1'b0;
    end else begin
      status_suppress_q <= frc_active | frc_req;
    end
  end

  // ============================================================
  // Stop handling
  // Exactly one of grant and refusal answers a stop, one cycle late
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      illegal_stop_q <= 1'b0;
    end else begin
      illegal_stop_q <= stop_exec && !opt1_q[`SOR_O1_STOP_OK];
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_grant_q <= 1'b0;
    end else begin
      stop_grant_q <= stop_exec && opt1_q[`SOR_O1_STOP_OK];
    end
  end

  // ============================================================
  // First options register outputs
  // Taken from the stored value, so a refused write never shows here
  // Watchdog is on out of reset until software writes the register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_enable_q <= O1_RST[`SOR_O1_WDG_EN];
    end else begin
      watchdog_enable_q <= opt1_q[`SOR_O1_WDG_EN];
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_long_timeout_q <= O1_RST[`SOR_O1_WDG_LONG];
    end else begin
      watchdog_long_timeout_q <= opt1_q[`SOR_O1_WDG_LONG];
    end
  end

  // Returns to set after every reset through the register reset value
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      debug_pin_enable_q <= O1_RST[`SOR_O1_DBG_PIN];
    end else begin
      debug_pin_enable_q <= opt1_q[`SOR_O1_DBG_PIN];
    end
  end

  // Kept across resets other than power-on by the register keep mask
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_pin_enable_q <= O1_RST[`SOR_O1_RST_PIN];
    end else begin
      reset_pin_enable_q <= opt1_q[`SOR_O1_RST_PIN];
    end
  end

  // The pullup follows the pin function and is never on for a general input
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_pin_pullup_q <= O1_RST[`SOR_O1_RST_PIN];
    end else begin
      reset_pin_pullup_q <= opt1_q[`SOR_O1_RST_PIN];
    end
  end

  // ============================================================
  // Second options register outputs
  // Watchdog clock pairs with the timeout bit to set the watchdog period
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_clock_select_q <= O2_RST[`SOR_O2_WDG_CLK];
    end else begin
      watchdog_clock_select_q <= opt2_q[`SOR_O2_WDG_CLK];
    end
  end

  // Filter on limits the serial port baud rate; off allows faster rates
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_port_filter_enable_q <= O2_RST[`SOR_O2_SPI_FILT];
    end else begin
      serial_port_filter_enable_q <= opt2_q[`SOR_O2_SPI_FILT];
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_port_pin_select_q <= O2_RST[`SOR_O2_SPI_PINS];
    end else begin
      serial_port_pin_select_q <= opt2_q[`SOR_O2_SPI_PINS];
    end
  end

  // Capture routing only connects the comparators; the timers decide the rest
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      comparator2_to_capture_q <= O2_RST[`SOR_O2_CMP2_CAP];
    end else begin
      comparator2_to_capture_q <= opt2_q[`SOR_O2_CMP2_CAP];
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      two_wire_pin_select_q <= O2_RST[`SOR_O2_TWI_PINS];
    end else begin
      two_wire_pin_select_q <= opt2_q[`SOR_O2_TWI_PINS];
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      comparator1_to_capture_q <= O2_RST[`SOR_O2_CMP1_CAP];
    end else begin
      comparator1_to_capture_q <= opt2_q[`SOR_O2_CMP1_CAP];
    end
  end
endmodule // sor_system_options

//--- tb/sor_checker.sv
// Port assertions for the system option registers
`timescale 1ns/1ns
`include "sor_map.vh"
module sor_checker (
  input wire sys_clk, // Bus clock
  input wire rst_b, // Power-on reset
  input wire [`SOR_ADDR_W-1:0] reg_addr, // Register index
  input wire reg_wr, // Program write
  input wire dbg_wr, // Debug write
  input wire reg_rd, // Read strobe
  input wire [7:0] reg_wdata, // Write data
  input wire stop_exec, // Stop instruction
  input wire [7:0] reg_rdata_q, // Read data
  input wire force_reset_q, // Forced reset
  input wire status_suppress_q, // Status flags held clear
  input wire illegal_stop_q, // Illegal stop
  input wire stop_grant_q, // Stop granted
  input wire watchdog_enable_q, // Watchdog on
  input wire debug_pin_enable_q, // Debug pin function
  input wire reset_pin_enable_q, // Reset pin function
  input wire reset_pin_pullup_q // Reset pin pullup
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ============================================================
  // Register port
  rd_force_zero_a: assert property (reg_rd && reg_addr == 2'h0 |=> reg_rdata_q == 8'h00)
    else $error("force register read not zero");
  rd_hole_zero_a: assert property (reg_rd && reg_addr == 2'h1 |=> reg_rdata_q[4:2] == 3'h0)
    else $error("options one bits 4 to 2 not zero");
  // ============================================================
  // Forced reset
  prog_no_force_a: assert property (reg_wr && !dbg_wr && reg_addr == 2'h0 && !force_reset_q |=> !force_reset_q)
    else $error("program write forced a reset");
  force_pulse_a: assert property (dbg_wr && !reg_wr && reg_addr == 2'h0 && reg_wdata[0] && !force_reset_q
    |=> force_reset_q [*5] ##1 !force_reset_q) else $error("forced reset pulse wrong");
  suppress_tie_a: assert property (status_suppress_q == force_reset_q)
    else $error("status suppress differs from forced reset");
  pin_back_a: assert property ($fell(force_reset_q) |-> debug_pin_enable_q && watchdog_enable_q)
    else $error("defaults not back after forced reset");
  rst_pin_keep_a: assert property (force_reset_q |=> $stable(reset_pin_enable_q))
    else $error("reset pin enable lost in forced reset");
  // ============================================================
  // Stop and pins
  stop_split_a: assert property (stop_exec |=> illegal_stop_q != stop_grant_q)
    else $error("stop neither granted nor refused");
  stop_idle_a: assert property (!stop_exec |=> !illegal_stop_q && !stop_grant_q)
    else $error("stop response without stop");
  pullup_tie_a: assert property (reset_pin_pullup_q == reset_pin_enable_q)
    else $error("pullup differs from reset pin enable");
endmodule // sor_checker
bind sor_system_options sor_checker sor_checker_inst (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .dbg_wr(dbg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .stop_exec(stop_exec),
  .reg_rdata_q(reg_rdata_q), .force_reset_q(force_reset_q), .status_suppress_q(status_suppress_q),
  .illegal_stop_q(illegal_stop_q), .stop_grant_q(stop_grant_q), .watchdog_enable_q(watchdog_enable_q),
  .debug_pin_enable_q(debug_pin_enable_q), .reset_pin_enable_q(reset_pin_enable_q),
  .reset_pin_pullup_q(reset_pin_pullup_q));

//--- tb/sor_dbg_host.sv
// Background debug host model issuing write commands
`timescale 1ns/1ns
module sor_dbg_host (
  input wire sys_clk, // Bus clock
  output reg dbg_wr, // Background write strobe
  output reg [1:0] h_addr, // Command address
  output reg [7:0] h_data, // Command data
  output reg bkgd_level // Level held on the debug pin
);
  initial begin
    dbg_wr = 1'h0;
    h_addr = 2'h3;
    h_data = 8'h5A;
    bkgd_level = 1'h1;
  end
  // ============================================================
  // Forced reset command; gap models a slow host
  task force_reset(input user_mode, input integer gap);
    begin
      repeat (gap) @(posedge sys_clk);
      #1;
      dbg_wr = 1'h1;
      h_addr = 2'h0;
      h_data = 8'h01;
      @(posedge sys_clk);
      #1;
      dbg_wr = 1'h0;
      bkgd_level = user_mode;
      h_addr = 2'h3;
      h_data = 8'hFE; // Released lines show the inverse, not the last value
    end
  endtask
endmodule // sor_dbg_host

//--- tb/sor_system_options_bench.sv
// Self-checking bench for the system option registers
`timescale 1ns/1ns
module sor_system_options_bench;
  reg sys_clk, rst_b, sys_reset, reg_wr, reg_rd, stop_exec;
  reg [1:0] t_addr;
  reg [7:0] t_data, d1, d2;
  reg [31:0] seed;
  integer err_count, checks, i, n;
  wire dbg_wr, bkgd_level;
  wire [1:0] h_addr, reg_addr;
  wire [7:0] h_data, reg_wdata, rdata;
  wire [14:0] cfg;
  assign reg_addr = dbg_wr ? h_addr : t_addr;
  assign reg_wdata = dbg_wr ? h_data : t_data;
  sor_dbg_host sor_dbg_host_inst (.sys_clk(sys_clk), .dbg_wr(dbg_wr), .h_addr(h_addr), .h_data(h_data),
    .bkgd_level(bkgd_level));
  sor_system_options sor_system_options_inst (.sys_clk(sys_clk), .rst_b(rst_b), .sys_reset(sys_reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .dbg_wr(dbg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .stop_exec(stop_exec), .reg_rdata_q(rdata), .force_reset_q(cfg[14]), .status_suppress_q(cfg[13]),
    .illegal_stop_q(cfg[12]), .stop_grant_q(cfg[11]), .watchdog_enable_q(cfg[10]), .watchdog_long_timeout_q(cfg[9]),
    .debug_pin_enable_q(cfg[8]), .reset_pin_enable_q(cfg[7]), .reset_pin_pullup_q(cfg[6]),
    .watchdog_clock_select_q(cfg[5]), .serial_port_filter_enable_q(cfg[4]), .serial_port_pin_select_q(cfg[3]),
    .comparator2_to_capture_q(cfg[2]), .two_wire_pin_select_q(cfg[1]), .comparator1_to_capture_q(cfg[0]));
  // ============================================================
  // Helpers
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  function [12:0] exp_cfg(input [7:0] o1, input [7:0] o2, input stp);
    exp_cfg = {stp & ~o1[5], stp & o1[5], o1[7], o1[6], o1[1], o1[0], o1[0], o2[7], o2[4:0]};
  endfunction
  task tick(input integer k);
    begin
      repeat (k) @(posedge sys_clk);
      #1;
    end
  endtask
  task check(input [63:0] name, input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [1:0] a, input [7:0] d);
    begin
      reg_wr = 1'h1;
      t_addr = a;
      t_data = d;
      tick(1);
      reg_wr = 1'h0;
      tick(1);
    end
  endtask
  task rd(input [1:0] a, input [7:0] exp);
    begin
      reg_rd = 1'h1;
      t_addr = a;
      tick(1);
      reg_rd = 1'h0;
      check("read", rdata, exp);
      tick(1);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ============================================================
  // Clock and main sequence
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_b, sys_reset, reg_wr, reg_rd, stop_exec, t_addr, t_data} = 0;
    {seed, err_count, checks} = {32'h0F161B26, 64'h0};
    tick(10);
    rst_b = 1'h1;
    tick(1);
    rd(2'h1, 8'hC2);
    rd(2'h3, 8'h00);
    check("pins", cfg[12:0], exp_cfg(8'hC2, 8'h00, 1'h0));
    wr(2'h0, 8'h01);
    tick(2);
    check("force", cfg[14:13], 2'h0);
    rd(2'h0, 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      seed = xs(seed);
      d1 = (i == 0) ? 8'hFF : seed[7:0];
      d2 = (i == 0) ? 8'hFF : seed[15:8];
      stop_exec = seed[16];
      wr(2'h1, d1);
      wr(2'h2, d2);
      wr(2'h1, ~d1);
      wr(2'h2, ~d2);
      rd(2'h1, d1 & 8'hE3);
      rd(2'h2, d2 & 8'h9F);
      check("config", cfg[12:0], exp_cfg(d1, d2, stop_exec));
      if (i % 2 == 1) begin
        sor_dbg_host_inst.force_reset(i[1], i);
        check("forced", {cfg[14:13], bkgd_level}, {2'h3, i[1]});
        n = 0;
        while (cfg[14] === 1'h1 && n < 10) begin
          tick(1);
          n = n + 1;
        end
        if (cfg[14] !== 1'h0) begin
          err_count = err_count + 1;
          stop_test;
        end
        check("pulse", n[15:0], 16'h0005);
      end else begin
        sys_reset = 1'h1;
        tick(1);
        sys_reset = 1'h0;
      end
      tick(2);
      rd(2'h1, 8'hC2 | (d1 & 8'h01));
      rd(2'h2, 8'h00);
      check("reset", cfg[12:0], exp_cfg(8'hC2 | (d1 & 8'h01), 8'h00, stop_exec));
      $display("test %0d done", i);
    end
    stop_test;
  end
endmodule // sor_system_options_bench
